// *** sac_pkg.sv ***
/*
  sac_pkg: constants and carrier types for the converter control block.
  Assumes a single 100 MHz core clock; the converter clock is an enable pulse.
*/
package sac_pkg;
  localparam int RES_BITS       = 10;
  localparam int BUS_BITS       = 8;
  localparam int CLK_PER_BIT    = 8;
  localparam int CORE_PERIOD_NS = 10;
  localparam int CONV_DIV       = 4;
  localparam int ONESHOT_NS     = 400;
  localparam int ONESHOT_CYC    = (ONESHOT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int LO_PAD_BITS    = BUS_BITS - 2;
  localparam logic [9:0] RESULT_ZERO = 10'h000;

  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
  } sac_strobe_type;

  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } sac_bus_out_type;
endpackage

// *** sac_ctrl.sv ***
/*
  sac_ctrl: digital sequencing of a 10-bit successive-approximation converter
  behind a select/read/write strobe port.
  Assumes strobes come from pins (synchronised here) and comparator from analog.
*/
`timescale 1ns/1ns
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int DIV = CONV_DIV
)
(
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // host strobes
  input  wire logic              sel_n_in,
  input  wire logic              rd_n_in,
  input  wire logic              wr_n_in,
  // analog side
  input  wire logic              comp_high_in,
  input  wire logic              neg_ge_pos_in,
  output logic [RES_BITS-1:0]    dac_code_out,
  // host outputs
  output logic [BUS_BITS-1:0]    data_bus_out,
  output logic                   data_bus_oe_out,
  output logic                   conversion_done_n_out
);
  // the divider counter is eight bits wide
  if (DIV < 2 || DIV > 256)
  begin : g_div_check
    $error("DIV must lie between 2 and 256");
  end

  // ------------------------------------------------------------
  // pin synchronisers and converter clock divider
  // ------------------------------------------------------------
  sac_strobe_type s1, s2, s3, next_s1, filt, next_filt;
  logic [7:0] div_cnt, next_div_cnt;
  logic       conv_tick;

  always_comb
  begin
    next_s1 = '{sel_n: sel_n_in, rd_n: rd_n_in, wr_n: wr_n_in};
    // majority of stages two, three and the held level: a lone stage cannot flip it
    next_filt = (s2 & s3) | ((s2 | s3) & filt);
    next_div_cnt = (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      filt <= '1;
      div_cnt <= 8'h00;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      div_cnt <= next_div_cnt;
    end
  end

  assign conv_tick = (div_cnt == 8'h00);
  // filt only takes a new level once stages two and three agree
  logic start_cond, read_cond;
  assign start_cond = !filt.sel_n && !filt.wr_n;
  assign read_cond  = !filt.sel_n && !filt.rd_n;

  // ------------------------------------------------------------
  // sequencing: start flag, timing and bit shift registers
  // ------------------------------------------------------------
  logic                start_flag, next_start_flag;
  logic [2:0]          timing, next_timing;
  logic [RES_BITS-1:0] seq, next_seq;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] approx, next_approx;
  logic [RES_BITS-1:0] latch, next_latch;
  logic                result_transfer, next_result_transfer;

  always_comb
  begin
    next_start_flag = start_flag;
    next_timing     = timing;
    next_seq        = seq;
    next_approx     = approx;
    next_latch      = latch;
    next_result_transfer       = 1'b0;
    // one-hot trial bit: token in stage i tests result bit RES_BITS-1-i
    for (int i = 0; i < RES_BITS; i++)
    begin
      trial[RES_BITS-1-i] = seq[i];
    end
    if (start_cond)
    begin
      next_start_flag = 1'b1;
      next_timing     = 3'h0;
      next_seq        = '0;
      next_approx     = '0;
    end
    else if (conv_tick)
    begin
      if (start_flag)
      begin
        // release the flag only once the set condition is gone
        next_start_flag = 1'b0;
        next_seq        = {{(RES_BITS-1){1'b0}}, 1'b1};
        next_approx     = {1'b1, {(RES_BITS-1){1'b0}}};
        next_timing     = 3'h0;
      end
      else if (seq != '0)
      begin
        next_timing = timing + 3'h1;
        if (timing == 3'(CLK_PER_BIT - 1))
        begin
          next_seq = seq << 1;
          // keep the trial bit only while the input exceeds the trial level
          if (!comp_high_in || neg_ge_pos_in)
            next_approx = approx & ~trial;
          // the next lower bit becomes the new trial; none follows the lsb
          next_approx = next_approx | (trial >> 1);
          if (seq[RES_BITS-1])
          begin
            next_seq  = '0;
            next_result_transfer = 1'b1;
          end
        end
      end
    end
    if (result_transfer)
      next_latch = approx;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      start_flag <= 1'b0;
      timing <= 3'h0;
      seq <= '0;
      approx <= RESULT_ZERO;
      latch <= RESULT_ZERO;
      result_transfer <= 1'b0;
    end
    else
    begin
      start_flag <= next_start_flag;
      timing <= next_timing;
      seq <= next_seq;
      approx <= next_approx;
      latch <= next_latch;
      result_transfer <= next_result_transfer;
    end
  end

  // ------------------------------------------------------------
  // completion flag, one-shot, read port
  // ------------------------------------------------------------
  logic [7:0] shot, next_shot;
  logic       done, next_done;
  logic       hi_sel, next_hi_sel;
  logic       read_prev, next_read_prev;
  sac_bus_out_type next_bus;

  always_comb
  begin
    next_shot      = (shot != 8'h00) ? shot - 8'h01 : 8'h00;
    next_done      = done;
    next_hi_sel    = hi_sel;
    next_read_prev = read_cond;
    if (result_transfer)
      next_shot = 8'(ONESHOT_CYC);
    if (read_cond || start_cond)
      next_done = 1'b0;
    if (next_shot != 8'h00)
      next_done = 1'b1;
    if (result_transfer)
      next_hi_sel = 1'b1;
    else if (read_prev && !read_cond)
      next_hi_sel = !hi_sel;
    next_bus.oe   = read_cond;
    next_bus.data = hi_sel ? latch[9:2] : {latch[1:0], {LO_PAD_BITS{1'b0}}};
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      shot <= 8'h00;
      done <= 1'b0;
      hi_sel <= 1'b1;
      read_prev <= 1'b0;
      data_bus_out <= '0;
      data_bus_oe_out <= 1'b0;
      conversion_done_n_out <= 1'b1;
      dac_code_out <= '0;
    end
    else
    begin
      shot <= next_shot;
      done <= next_done;
      hi_sel <= next_hi_sel;
      read_prev <= next_read_prev;
      data_bus_out <= next_bus.data;
      data_bus_oe_out <= next_bus.oe;
      conversion_done_n_out <= !next_done;
      dac_code_out <= next_approx;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hold_reset;
    @(posedge core_clk_in) disable iff (!rst_n_in) start_cond |=> (seq == '0);
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("seq not held");

  property p_done_pulse;
    @(posedge core_clk_in) disable iff (!rst_n_in) result_transfer |=> ##1 !conversion_done_n_out [*8];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse short");

  property p_oe;
    @(posedge core_clk_in) disable iff (!rst_n_in) data_bus_oe_out == $past(read_cond);
  endproperty
  a_oe: assert property (p_oe) else $error("oe mismatch");

  property p_flag_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in) start_cond |=> start_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("start flag lost");

  property p_start;
    @(posedge core_clk_in) disable iff (!rst_n_in) $fell(start_flag) |-> seq == 10'h001;
  endproperty
  a_start: assert property (p_start) else $error("first stage empty");

  property p_msb;
    @(posedge core_clk_in) disable iff (!rst_n_in) $fell(start_flag) |-> approx == 10'h200;
  endproperty
  a_msb: assert property (p_msb) else $error("msb not first");

  property p_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in) result_transfer |=> latch == $past(approx);
  endproperty
  a_latch: assert property (p_latch) else $error("latch miss");

  property p_hibyte;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      read_cond && hi_sel && !result_transfer |=> data_bus_out == latch[9:2];
  endproperty
  a_hibyte: assert property (p_hibyte) else $error("high byte wrong");

  c_conv: cover property (@(posedge core_clk_in) result_transfer);
  c_read: cover property (@(posedge core_clk_in) read_cond && !hi_sel);
  c_abort: cover property (@(posedge core_clk_in) start_cond && seq != '0);
endmodule // sac_ctrl

// *** sac_host_model.sv ***
/*
  sac_host_model: host bus partner that drives select, read and write strobes.
  Assumes the block samples strobes on the rising core clock edge.
*/
`timescale 1ns/1ns
module sac_host_model
(
  // clock
  input  wire logic       clk_in,
  // read data from the block
  input  wire logic [7:0] data_in,
  input  wire logic       oe_in,
  // strobes, active low
  output logic            sel_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);
  initial {sel_n_out, rd_n_out, wr_n_out} = 3'h7;

  // strobes move only after a falling edge, away from the sampling edge
  task automatic drive(input logic s, input logic r, input logic w);
    @(negedge clk_in);
    {sel_n_out, rd_n_out, wr_n_out} = {s, r, w};
  endtask

  // start pulse; the first one after power-up is the required write
  task automatic start_conv(input int hold);
    drive(1'b0, 1'b1, 1'b0);
    repeat (hold) @(negedge clk_in);
    drive(1'b1, 1'b1, 1'b1);
  endtask

  // held long enough for the three-flop synchroniser, then a gap
  task automatic read_byte(output logic [7:0] b, output logic oe);
    drive(1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge clk_in);
    b  = data_in;
    oe = oe_in;
    drive(1'b1, 1'b1, 1'b1);
    repeat (8) @(negedge clk_in);
  endtask
endmodule // sac_host_model

// *** tb.sv ***
/*
  tb: self-checking bench for sac_ctrl with a host model on the strobes.
  Assumes a behavioural comparator that keeps a trial bit while target >= trial.
*/
`timescale 1ns/1ns
module tb;
  import sac_pkg::*;
  logic                core_clk_in = 1'b0;
  logic                rst_n_in    = 1'b0;
  logic                neg_ge_pos  = 1'b0;
  logic                free_run    = 1'b0;
  logic [9:0]          target      = 10'h000;
  logic [RES_BITS-1:0] dac_code;
  logic [BUS_BITS-1:0] data_bus;
  logic                oe;
  logic                done_n;
  logic                sel_n;
  logic                rd_n;
  logic                wr_n_host;
  int                  errors = 0;
  int                  checks = 0;
  wire logic           comp_high = (dac_code <= target);
  // free-running loop: done output closed onto the write strobe
  wire logic           wr_n = free_run ? done_n : wr_n_host;

  always #5 core_clk_in = ~core_clk_in;

  sac_ctrl i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sel_n_in(sel_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .comp_high_in(comp_high), .neg_ge_pos_in(neg_ge_pos), .dac_code_out(dac_code),
    .data_bus_out(data_bus), .data_bus_oe_out(oe), .conversion_done_n_out(done_n));
  sac_host_model i_host (.clk_in(core_clk_in), .data_in(data_bus), .oe_in(oe), .sel_n_out(sel_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n_host));

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait, so a stuck flag cannot hang the run
  task automatic wait_level(input logic lvl, output int n);
    n = 0;
    while (done_n !== lvl && n < 2000)
    begin
      @(negedge core_clk_in);
      n++;
    end
  endtask

  task automatic conv_read(input logic [9:0] t, input logic neg, input int hold);
    logic [9:0] e;
    logic [7:0] b;
    logic       v;
    int         n;
    e          = neg ? 10'h000 : t;
    target     = t;
    neg_ge_pos = neg;
    i_host.start_conv(hold);
    wait_level(1'b0, n);
    chk(16'(n >= 320 && n <= 360), 16'h0001);
    // once the one-shot has run out with no read, the flag must still be set
    repeat (ONESHOT_CYC + 2) @(negedge core_clk_in);
    chk(16'(done_n), 16'h0000);
    i_host.read_byte(b, v);
    chk(16'(v), 16'h0001);
    chk(16'(b), 16'(e[9:2]));
    chk(16'(done_n), 16'h0001);
    i_host.read_byte(b, v);
    chk(16'({b, oe}), 16'({e[1:0], 6'h00, 1'b0}));
  endtask

  task automatic t_abort();
    target = 10'h0f0;
    i_host.start_conv(4);
    repeat (150) @(negedge core_clk_in);
    conv_read(10'h30f, 1'b0, 4);
  endtask

  task automatic t_held_read();
    int n;
    target = 10'h3ff;
    i_host.drive(1'b0, 1'b1, 1'b0);
    repeat (8) @(negedge core_clk_in);
    chk(16'(dac_code), 16'h0000);
    i_host.drive(1'b0, 1'b0, 1'b1);
    wait_level(1'b0, n);
    wait_level(1'b1, n);
    chk(16'(n >= 40 && n <= 44), 16'h0001);
    i_host.drive(1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_free();
    int n;
    i_host.drive(1'b0, 1'b1, 1'b0);
    repeat (4) @(negedge core_clk_in);
    free_run = 1'b1;
    wait_level(1'b0, n);
    wait_level(1'b1, n);
    chk(16'(n >= 40 && n <= 44), 16'h0001);
    wait_level(1'b0, n);
    chk(16'(n >= 320 && n <= 360), 16'h0001);
    free_run = 1'b0;
    i_host.drive(1'b1, 1'b1, 1'b1);
  endtask

  initial
  begin
    repeat (10) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    conv_read(10'h3ff, 1'b0, 4);
    conv_read(10'h000, 1'b0, 4);
    conv_read(10'h2aa, 1'b0, 30);
    conv_read(10'h155, 1'b1, 4);
    conv_read(10'h1c7, 1'b0, 500);
    t_abort();
    t_held_read();
    t_free();
    wrap_up();
  end

  // watchdog: about ten conversions fit well inside this span
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    errors++;
    wrap_up();
  end
endmodule // tb
